// ### rtl/mcr_pkg.sv
// Shared constants and carrier types for the memory cube response link port
package mcr_pkg;
  // ===========================================================
  // Register map (byte offsets)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FCNT_OFS = 8'h08;
  // ===========================================================
  // Control fields
  localparam int CTRL_RST_REL = 0;
  localparam int CTRL_TXPS = 1;
  localparam int CTRL_PAUSE = 2;
  localparam int CTRL_REQ_EN = 3;
  localparam int CTRL_LINK_EN = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // ===========================================================
  // Status fields
  localparam int STAT_FATAL = 0;
  localparam int STAT_FERR_LVL = 1;
  localparam int STAT_IN_PKT = 2;
  // ===========================================================
  // Bus answers and widths
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CODE_W = 7;
  localparam int CMD_W = 6;
  localparam int CMD_NOPAY = 0;
  localparam int SIZE_W = 3;
  localparam int FIFO_DEPTH = 32;

  // One response beat as it arrives from the link decoder
  typedef struct packed {
    logic first;
    logic last;
    logic [CMD_W-1:0] cmd;
    logic [SIZE_W-1:0] size;
    logic [CODE_W-1:0] errstat;
    logic packet_data_invalid_field;
  } mcr_beat_t;

  // Response marks handed to the application
  typedef struct packed {
    logic first;
    logic last;
    logic fail;
    logic [CODE_W-1:0] code;
    logic [CMD_W-1:0] cmd;
    logic [SIZE_W-1:0] size;
  } mcr_rsp_t;
endpackage : mcr_pkg

// ### rtl/mcr_link_port.sv
// Response port, link pins and AXI4-Lite registers of the cube controller
// Overview of operation
// - Fail flag rises when a response has non-zero error status or data-invalid.
// - Fail flag stays constant over every beat of a multi-beat response.
// - First-beat marker is set in the first cycle of each response.
// - Last-beat marker set in final cycle; single beat sets both.
// - Seven-bit fail code copies the packet error status unmodified.
// - Receive lanes: sixteen full width, eight half width.
// - Transmit lanes: sixteen full width, eight half width.
// - Power-reduction input exists only for compliance and is ignored.
// - Power-reduction output drives the cube's power-reduction input.
// - Active-low fatal error input; low means fatal cube error.
// - Active-low main reset output drives the cube's primary reset.
// - Command bit 0 set means no payload; size and data undefined.

// ===========================================================
// Response buffer
module mcr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Sync reset, active low
  input wire logic [W-1:0] in_data, // Fill data
  input wire logic in_valid, // Fill valid
  output logic in_ready, // Not full
  output logic [W-1:0] out_data, // Head word
  output logic out_valid, // Not empty
  input wire logic out_ready // Drain
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("mcr_fifo: DEPTH must be a power of two");
  end
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mcr_fifo

// ===========================================================
// Top level
module mcr_link_port #(
  parameter int LANES = 16,
  parameter int DW = 512
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic nrst, // Sync reset, active low
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  // Beats from the link decoder
  input wire mcr_pkg::mcr_beat_t beat_in, // Beat marks and header
  input wire logic [DW-1:0] beat_data, // Beat payload
  input wire logic beat_valid, // Beat valid
  output logic beat_ready, // Buffer has room
  // Application response port
  output logic response_valid, // Beat valid, no back-pressure
  output mcr_pkg::mcr_rsp_t response_out, // Markers, fail flag, code
  output logic [DW-1:0] response_data, // Read payload
  output logic request_accept, // Request side may take values
  // Cube link pins
  input wire logic [LANES-1:0] lane_rx, // Serial receive lanes
  output logic [LANES-1:0] lane_tx, // Serial transmit lanes
  output logic [LANES-1:0] lane_rx_word, // Sampled receive lanes
  input wire logic [LANES-1:0] lane_tx_word, // Word to transmit
  input wire logic link_psr_in, // Power reduction in, unused
  output logic link_psr_out, // Power reduction out
  input wire logic cube_fatal_n, // Fatal error, active low
  output logic cube_rst_n // Cube main reset, active low
);
  localparam int BW = $bits(mcr_pkg::mcr_beat_t);
  initial
  begin
    if (LANES != 16 && LANES != 8)
      $error("mcr_link_port: LANES must be 16 or 8");
  end
  // ===========================================================
  // Buffer between link decoder and response port
  logic [4:0] ctrl_q;
  logic f_valid;
  logic f_pop;
  logic [BW+DW-1:0] f_word;
  mcr_pkg::mcr_beat_t hb;
  logic [DW-1:0] hd;
  mcr_fifo #(.W(BW+DW), .DEPTH(mcr_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_data({beat_in, beat_data}),
    .in_valid(beat_valid),
    .in_ready(beat_ready),
    .out_data(f_word),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );
  assign hb = f_word[BW+DW-1:DW];
  assign hd = f_word[DW-1:0];
  // Pause stalls the drain so software can let the buffer fill
  assign f_pop = f_valid && !ctrl_q[mcr_pkg::CTRL_PAUSE];

  // ===========================================================
  // Response stage
  logic in_pkt_q;
  logic fail_now;
  logic [31:0] fcnt_q;
  assign fail_now = (hb.errstat != '0) || hb.packet_data_invalid_field;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      in_pkt_q <= 1'b0;
    else if (f_pop)
      in_pkt_q <= !hb.last;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      response_valid <= 1'b0;
      response_out <= '0;
      response_data <= '0;
    end
    else
    begin
      // No back-pressure: each popped beat is shown for one cycle
      response_valid <= f_pop;
      response_out.first <= f_pop && !in_pkt_q;
      response_out.last <= f_pop && hb.last;
      if (f_pop && !in_pkt_q)
      begin
        // Status is caught on the first beat and held to the last
        response_out.fail <= fail_now;
        response_out.code <= hb.errstat;
        response_out.cmd <= hb.cmd;
        response_out.size <= hb.size;
      end
      if (f_pop)
        // Payload-free responses show zero data
        response_data <= hb.cmd[mcr_pkg::CMD_NOPAY] ? '0 : hd;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      fcnt_q <= '0;
    else if (f_pop && !in_pkt_q && fail_now)
      fcnt_q <= fcnt_q + 32'h1;
  end

  // ===========================================================
  // Link pins
  logic fatal_q;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      lane_rx_word <= '0;
      lane_tx <= '0;
    end
    else
    begin
      lane_rx_word <= lane_rx;
      lane_tx <= ctrl_q[mcr_pkg::CTRL_LINK_EN] ? lane_tx_word : '0;
    end
  end

  // The incoming power-reduction level is deliberately left unread
  assign link_psr_out = ctrl_q[mcr_pkg::CTRL_TXPS];
  assign cube_rst_n = ctrl_q[mcr_pkg::CTRL_RST_REL];
  assign request_accept = ctrl_q[mcr_pkg::CTRL_REQ_EN] && !fatal_q;

  // ===========================================================
  // AXI4-Lite slave
  logic wr_go;
  logic wr_clr;
  logic [31:0] stat_w;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_clr = wr_go && s_axi_awaddr == mcr_pkg::STAT_OFS
    && s_axi_wstrb[0] && s_axi_wdata[mcr_pkg::STAT_FATAL];
  assign stat_w = {29'h0, in_pkt_q, !cube_fatal_n, fatal_q};

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      ctrl_q <= mcr_pkg::CTRL_RESET;
    else if (wr_go && s_axi_awaddr == mcr_pkg::CTRL_OFS && s_axi_wstrb[0])
      ctrl_q <= s_axi_wdata[4:0];
  end

  // Sticky fatal flag; a new fault wins over a clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      fatal_q <= 1'b0;
    else if (!cube_fatal_n)
      fatal_q <= 1'b1;
    else if (wr_clr)
      fatal_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mcr_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == mcr_pkg::CTRL_OFS
        || s_axi_awaddr == mcr_pkg::STAT_OFS)
        ? mcr_pkg::RESP_OKAY : mcr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= mcr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mcr_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        mcr_pkg::CTRL_OFS: s_axi_rdata <= {27'h0, ctrl_q};
        mcr_pkg::STAT_OFS: s_axi_rdata <= stat_w;
        mcr_pkg::FCNT_OFS: s_axi_rdata <= fcnt_q;
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= mcr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ===========================================================
  // Checks
  sequence s_head;
    f_pop && !in_pkt_q;
  endsequence

  a_fail_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_head |=> response_out.fail == ($past(hb.errstat) != '0
      || $past(hb.packet_data_invalid_field)))
    else $error("fail flag does not follow response status");
  a_fail_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    response_valid && !response_out.first |-> $stable(response_out.fail))
    else $error("fail flag changed inside a response");
  a_first_mark: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_head |=> response_valid && response_out.first)
    else $error("first beat not marked");
  a_last_mark: assert property (@(posedge ref_clk) disable iff (!nrst)
    f_pop && hb.last ##1 response_valid |-> response_out.last
      ##1 (!response_valid || response_out.first))
    else $error("last beat not marked or next not first");
  a_code_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_head |=> response_out.code == $past(hb.errstat))
    else $error("fail code not copied");
  a_rx_sample: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> lane_rx_word == $past(lane_rx))
    else $error("receive lanes not sampled");
  a_tx_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl_q[mcr_pkg::CTRL_LINK_EN] |=> lane_tx == $past(lane_tx_word))
    else $error("transmit lanes not driven");
  a_fatal_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cube_fatal_n |=> fatal_q && !request_accept)
    else $error("fatal error not caught");
  a_rst_out: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_go && s_axi_awaddr == mcr_pkg::CTRL_OFS && s_axi_wstrb[0]
      && !s_axi_wdata[mcr_pkg::CTRL_RST_REL] |=> !cube_rst_n)
    else $error("cube reset not asserted");
  a_marks_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !response_valid |-> !response_out.first && !response_out.last)
    else $error("markers set without valid");
endmodule : mcr_link_port

// ### dv/mcr_cube_model.sv
// Far-side model: link decoder beats, cube lanes and cube status pins
module mcr_cube_model (
  input wire logic ref_clk, // Clock
  input wire logic beat_ready, // Buffer room
  output mcr_pkg::mcr_beat_t beat_in, // Beat header
  output logic [511:0] beat_data, // Beat payload
  output logic beat_valid, // Beat valid
  output logic [15:0] lane_rx, // Cube transmit lanes
  output logic link_psr_in, // Cube power reduction
  output logic cube_fatal_n // Fatal error, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    beat_in = '0;
    beat_data = '0;
    beat_valid = 1'b0;
    lane_rx = 16'h0;
    link_psr_in = 1'b0;
    cube_fatal_n = 1'b1;
  end
  // The power pin toggles all the time: the port must not react to it
  always @(posedge ref_clk)
  begin
    lane_rx <= 16'($urandom);
    link_psr_in <= ~link_psr_in;
  end
  task automatic set_fatal(input logic v);
    cube_fatal_n <= v;
  endtask : set_fatal
  // Later beats carry noise in the status fields; only the header counts
  task automatic send_pkt(input int nb, input logic [6:0] es,
    input logic dv, input logic [5:0] cmd);
    @(posedge ref_clk);
    for (int i = 0; i < nb; i++)
    begin
      beat_in <= '{first: i == 0, last: i == nb - 1, cmd: cmd,
        size: 3'($urandom), errstat: (i == 0) ? es : 7'($urandom),
        packet_data_invalid_field: (i == 0) ? dv : 1'($urandom)};
      beat_data <= {16{$urandom}};
      beat_valid <= 1'b1;
      do @(posedge ref_clk); while (beat_ready !== 1'b1);
    end
    beat_valid <= 1'b0;
    beat_in <= ~beat_in;
    beat_data <= ~beat_data;
  endtask : send_pkt
endmodule : mcr_cube_model

// ### dv/mcr_link_port_tb.sv
// Self-checking bench for the response port and cube link pins
module mcr_link_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  mcr_pkg::mcr_beat_t beat_in;
  mcr_pkg::mcr_rsp_t response_out, e;
  logic [511:0] beat_data, response_data, d;
  logic beat_valid, beat_ready, response_valid, request_accept;
  logic [15:0] lane_rx, lane_tx, lane_rx_word, ptx, prx;
  logic [15:0] lane_tx_word = 16'h0;
  logic link_psr_in, link_psr_out, cube_fatal_n, cube_rst_n;
  logic in_pkt, cf, lk, chk_lanes;
  logic [6:0] cc;
  logic [2:0] cs;
  mcr_pkg::mcr_rsp_t eq[$];
  logic [511:0] dq[$];
  int num_errors = 0, n_tests = 0, n_acc = 0, base, nf = 0;
  always #20 ref_clk = ~ref_clk;
  mcr_link_port #(.LANES(16), .DW(512)) dut_u (.ref_clk(ref_clk),
    .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .beat_in(beat_in), .beat_data(beat_data),
    .beat_valid(beat_valid), .beat_ready(beat_ready),
    .response_valid(response_valid), .response_out(response_out),
    .response_data(response_data), .request_accept(request_accept),
    .lane_rx(lane_rx), .lane_tx(lane_tx), .lane_rx_word(lane_rx_word),
    .lane_tx_word(lane_tx_word), .link_psr_in(link_psr_in),
    .link_psr_out(link_psr_out), .cube_fatal_n(cube_fatal_n),
    .cube_rst_n(cube_rst_n));
  mcr_cube_model cube_u (.ref_clk(ref_clk), .beat_ready(beat_ready),
    .beat_in(beat_in), .beat_data(beat_data), .beat_valid(beat_valid),
    .lane_rx(lane_rx), .link_psr_in(link_psr_in),
    .cube_fatal_n(cube_fatal_n));
  // ===========================================================
  // Checking and closing
  task automatic chk(input logic [511:0] g, input logic [511:0] x);
    n_tests++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, x);
    end
  endtask : chk
  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // ===========================================================
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    // One idle edge so a following call never re-raises ready at once
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [1:0] er, input logic [31:0] m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    chk(s_axi_rdata & m, x);
    @(posedge ref_clk);
  endtask : rd
  // ===========================================================
  // Reference model of the response port, compared on every beat
  always @(posedge ref_clk)
  begin
    if (nrst !== 1'b1)
      in_pkt = 1'b0;
    else
    begin
      if (beat_valid === 1'b1 && beat_ready === 1'b1)
      begin
        if (!in_pkt)
        begin
          cf = beat_in.errstat != 7'h0 || beat_in.packet_data_invalid_field;
          cc = beat_in.errstat;
          cs = beat_in.size;
          if (cf)
            nf++;
        end
        eq.push_back('{first: !in_pkt, last: beat_in.last, fail: cf,
          code: cc, cmd: beat_in.cmd, size: cs});
        dq.push_back(beat_in.cmd[0] ? 512'h0 : beat_data);
        in_pkt = !beat_in.last;
        n_acc++;
      end
      if (response_valid === 1'b1)
      begin
        e = eq.pop_front();
        d = dq.pop_front();
        chk(response_out.first, e.first);
        chk(response_out.last, e.last);
        chk(response_out.fail, e.fail);
        chk(response_out.code, e.code);
        chk(response_out.cmd, e.cmd);
        if (!e.cmd[0])
          chk(response_out.size, e.size);
        chk(response_data, d);
      end
    end
  end
  // Lanes: one register in each direction
  always @(posedge ref_clk)
  begin
    lane_tx_word <= 16'($urandom);
    ptx <= lane_tx_word;
    prx <= lane_rx;
    if (chk_lanes)
    begin
      chk(lane_tx, lk ? ptx : 16'h0);
      chk(lane_rx_word, prx);
    end
  end
  initial
  begin
    #800000;
    num_errors++;
    end_sim();
  end
  // ===========================================================
  // Main sequence
  initial
  begin
    chk_lanes = 1'b0;
    lk = 1'b1;
    void'($urandom(32'h671a));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(cube_rst_n, 1'b0);
    chk(link_psr_out, 1'b0);
    chk(request_accept, 1'b0);
    rd(mcr_pkg::CTRL_OFS, 32'h0, mcr_pkg::RESP_OKAY, 32'h1f);
    wr(mcr_pkg::CTRL_OFS, 32'h1b, mcr_pkg::RESP_OKAY);
    chk(cube_rst_n, 1'b1);
    chk(link_psr_out, 1'b1);
    chk(request_accept, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk_lanes = 1'b1;
    for (int k = 0; k < 12; k++)
      cube_u.send_pkt(1 + $urandom % 4, (k % 3 == 0) ? 7'h0 :
        7'($urandom) | 7'h1, k % 4 == 1, 6'(k));
    repeat (10) @(posedge ref_clk);
    chk(eq.size(), 0);
    rd(mcr_pkg::FCNT_OFS, nf, mcr_pkg::RESP_OKAY, 32'hffffffff);
    chk_lanes = 1'b0;
    wr(mcr_pkg::CTRL_OFS, 32'h0b, mcr_pkg::RESP_OKAY);
    lk = 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_lanes = 1'b1;
    cube_u.set_fatal(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(request_accept, 1'b0);
    rd(mcr_pkg::STAT_OFS, 32'h1, mcr_pkg::RESP_OKAY, 32'h1);
    cube_u.set_fatal(1'b1);
    repeat (3) @(posedge ref_clk);
    wr(mcr_pkg::STAT_OFS, 32'h1, mcr_pkg::RESP_OKAY);
    rd(mcr_pkg::STAT_OFS, 32'h0, mcr_pkg::RESP_OKAY, 32'h1);
    chk(request_accept, 1'b1);
    rd(8'h0c, 32'h0, mcr_pkg::RESP_SLVERR, 32'hffffffff);
    wr(mcr_pkg::FCNT_OFS, 32'h5, mcr_pkg::RESP_SLVERR);
    // Hold the drain so the buffer fills and refuses
    wr(mcr_pkg::CTRL_OFS, 32'h0f, mcr_pkg::RESP_OKAY);
    base = n_acc;
    fork
      for (int k = 0; k < 40; k++)
        cube_u.send_pkt(1, 7'h0, 1'b0, 6'($urandom));
    join_none
    repeat (100) @(posedge ref_clk);
    chk(n_acc - base, mcr_pkg::FIFO_DEPTH);
    chk(beat_ready, 1'b0);
    wr(mcr_pkg::CTRL_OFS, 32'h0b, mcr_pkg::RESP_OKAY);
    wait fork;
    repeat (40) @(posedge ref_clk);
    chk(eq.size(), 0);
    end_sim();
  end
endmodule : mcr_link_port_tb
